// ### rtl/fic_pkg.sv
// package for the settings checksum and fault injection block
// holds command codes, field positions, reset values and the carrier types
// assumes a pmbus front end that decodes word transactions on clk_in
package fic_pkg;

  // command codes of the two vendor commands
  localparam logic [7:0] CMD_CRC = 8'hF0;
  localparam logic [7:0] CMD_INJECT = 8'hF1;

  // crc settings
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_RESET = 16'h0000;

  // size of the settings store walked by the checksum
  localparam int NVM_ADDR_W = 8;
  localparam logic [7:0] NVM_LAST_ADDR = 8'hFF;

  // field positions of the injection control word
  localparam int BIT_FAULT_PERSIST = 15;
  localparam int BIT_OVERTEMP_F = 14;
  localparam int BIT_OVERCURRENT_F = 12;
  localparam int BIT_LOCKOUT_F = 11;
  localparam int BIT_IN_OV_F = 10;
  localparam int BIT_OUT_UV_F = 9;
  localparam int BIT_OUT_OV_F = 8;
  localparam int BIT_WARN_PERSIST = 7;
  localparam int BIT_OVERCURRENT_W = 4;
  localparam int BIT_IN_UV_W = 3;
  localparam int BIT_OUT_UV_W = 1;
  localparam int BIT_OUT_OV_W = 0;

  // bits that store anything; 13, 6, 5 and 2 always read zero
  localparam logic [15:0] INJECT_USED_MASK = 16'hDF9B;
  // fault select bits withdrawn after one response
  localparam logic [15:0] INJECT_FAULT_SEL = 16'h5F00;
  // warning select bits withdrawn after one response
  localparam logic [15:0] INJECT_WARN_SEL = 16'h001B;
  localparam logic [15:0] INJECT_RESET = 16'h0000;

  // forced detector outputs for faults
  typedef struct packed {
    logic inject_overtemp_fault;
    logic inject_overcurrent_fault;
    logic inject_input_lockout;
    logic inject_input_overvolt_fault;
    logic inject_output_undervolt_fault;
    logic inject_output_overvolt_fault;
  } fic_fault_t;

  // forced detector outputs for warnings
  typedef struct packed {
    logic inject_overcurrent_warning;
    logic inject_input_undervolt_warning;
    logic inject_output_undervolt_warning;
    logic inject_output_overvolt_warning;
  } fic_warn_t;

  // one settings byte folded into the crc, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] acc,
                                           input logic [7:0] data);
    logic [15:0] c;
    c = acc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_byte

endpackage : fic_pkg

// ### rtl/fic_crc_engine.sv
// byte-serial crc walker over the settings store
// assumes the store returns read data one cycle after the address
`timescale 1ns/10ps
`default_nettype none
module fic_crc_engine (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [7:0] nvm_data_in,
  output logic [7:0] nvm_addr_out,
  output logic busy_out,
  output logic [15:0] crc_out
);

  logic busy_q;
  logic busy_out_q;
  logic take_q;
  logic [7:0] addr_q;
  logic [15:0] acc_q;
  logic [15:0] crc_q;
  logic [15:0] acc_next;
  logic last_addr;

  // fold of the byte that arrives this cycle
  assign acc_next = fic_pkg::crc_byte(acc_q, nvm_data_in);
  assign last_addr = (addr_q == fic_pkg::NVM_LAST_ADDR);

  // a new start restarts the walk; the old result stays until it ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
      take_q <= 1'b0;
      addr_q <= 8'h00;
      acc_q <= fic_pkg::CRC_INIT;
      crc_q <= fic_pkg::CRC_RESET;
    end else if (start_in) begin
      busy_q <= 1'b1;
      take_q <= 1'b0;
      addr_q <= 8'h00;
      acc_q <= fic_pkg::CRC_INIT;
    end else begin
      take_q <= busy_q;
      if (busy_q && last_addr) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        addr_q <= addr_q + 8'h01;
      end
      if (take_q) begin
        acc_q <= acc_next;
      end
      if (take_q && !busy_q) begin
        crc_q <= acc_next;
      end
    end
  end

  // busy level from its own flop; the next busy-or-take is busy_q or a start
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_out_q <= 1'b0;
    end else begin
      busy_out_q <= start_in | busy_q;
    end
  end

  assign nvm_addr_out = addr_q;
  assign busy_out = busy_out_q;
  assign crc_out = crc_q;

endmodule : fic_crc_engine
`default_nettype wire

// ### rtl/fic_top.sv
// settings checksum report and fault injection control
// assumes a pmbus front end on clk_in that hands over decoded word reads
// and writes, a settings store with one-cycle read latency, and a fault
// handler that pulses once per completed fault response
// no interrupt of its own; the fault handler reacts to the forced levels
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - checksum is crc-16, polynomial 0x8005, over the stored settings bytes.
// - checksum recomputed at boot and after each store or restore.
// - checksum register is read only; writes to it are refused.
// - writing injection register forces selected detector outputs active.
// - several selects in one write are all injected together.
// - bit 15 clear withdraws faults after one response; set keeps them.
// - bit 7 clear withdraws warnings after one response; set keeps them.
// - bits 14,12,11,10,9,8 select faults; zero injects nothing.
// - bits 4,3,1,0 select warnings; zero injects nothing.
// - bits 13,6,5,2 are unused and have no effect.
// - lockout and output overvoltage may trip while conversion is off.
// - other injections act only while conversion is enabled.
module fic_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic wr_word_in,
  input wire logic [15:0] wr_data_in,
  input wire logic rd_word_in,
  input wire logic store_done_in,
  input wire logic restore_done_in,
  input wire logic conv_enable_in,
  input wire logic fault_response_in,
  input wire logic [7:0] nvm_data_in,
  output logic [7:0] nvm_addr_out,
  output logic [15:0] rd_data_out,
  output logic rd_ack_out,
  output logic cmd_nack_out,
  output logic crc_busy_out,
  output var fic_pkg::fic_fault_t fault_force_out,
  output var fic_pkg::fic_warn_t warn_force_out
);

  logic boot_q;
  logic [15:0] inject_q;
  logic [15:0] inject_d;
  logic [15:0] rd_data_q;
  logic rd_ack_q;
  logic nack_q;
  fic_pkg::fic_fault_t fault_q;
  fic_pkg::fic_fault_t fault_d;
  fic_pkg::fic_warn_t warn_q;
  fic_pkg::fic_warn_t warn_d;
  logic [15:0] crc_value;
  logic crc_start;
  logic sel_crc;
  logic sel_inject;
  logic write_inject;
  logic read_ok;
  logic nack_d;
  logic [15:0] rd_data_d;
  logic [15:0] withdraw;
  logic [15:0] withdraw_fault;
  logic [15:0] withdraw_warn;
  logic fault_persist;
  logic warn_persist;
  logic foreign_code;
  logic write_crc;

  // a response drops a whole group of selects unless that group persists
  function automatic logic [15:0] withdraw_mask(
    input logic response,
    input logic persist,
    input logic [15:0] sel
  );
    return (response & ~persist) ? sel : 16'h0000;
  endfunction : withdraw_mask

  // gated detectors only see a force while the converter runs
  function automatic logic conv_gate(input logic sel, input logic conv);
    return sel & conv;
  endfunction : conv_gate

  // command decode
  assign sel_crc = (cmd_code_in == fic_pkg::CMD_CRC);
  assign sel_inject = (cmd_code_in == fic_pkg::CMD_INJECT);
  assign foreign_code = ~(sel_crc | sel_inject);
  assign write_inject = wr_word_in & sel_inject;
  assign write_crc = wr_word_in & sel_crc;
  assign read_ok = rd_word_in & ~foreign_code;

  // the checksum has no write path, so a write to it is refused outright
  assign nack_d = write_crc
    | (wr_word_in & foreign_code)
    | (rd_word_in & foreign_code);

  // answer mux; a foreign code never reaches it because read_ok is low
  assign rd_data_d = sel_crc ? crc_value : inject_q;

  // boot pass and every store or restore start a fresh walk
  assign crc_start = boot_q | store_done_in | restore_done_in;

  // persistence bits are stored like any other; a response leaves them
  assign fault_persist = inject_q[fic_pkg::BIT_FAULT_PERSIST];
  assign warn_persist = inject_q[fic_pkg::BIT_WARN_PERSIST];

  // one response withdraws every non-persistent group at once
  assign withdraw_fault = withdraw_mask(fault_response_in, fault_persist,
    fic_pkg::INJECT_FAULT_SEL);
  assign withdraw_warn = withdraw_mask(fault_response_in, warn_persist,
    fic_pkg::INJECT_WARN_SEL);
  // both groups fold into one clear mask for the injection register
  assign withdraw = withdraw_fault | withdraw_warn;

  // a write in the same cycle as a response wins, so no injection is lost
  assign inject_d = write_inject
    ? (wr_data_in & fic_pkg::INJECT_USED_MASK)
    : (inject_q & ~withdraw);

  // lockout and output overvoltage ignore the conversion gate
  assign fault_d.inject_input_lockout =
    inject_q[fic_pkg::BIT_LOCKOUT_F];
  assign fault_d.inject_output_overvolt_fault =
    inject_q[fic_pkg::BIT_OUT_OV_F];
  // the rest only act while converting, so persistence can cycle restarts
  assign fault_d.inject_overtemp_fault =
    conv_gate(inject_q[fic_pkg::BIT_OVERTEMP_F], conv_enable_in);
  assign fault_d.inject_overcurrent_fault =
    conv_gate(inject_q[fic_pkg::BIT_OVERCURRENT_F], conv_enable_in);
  assign fault_d.inject_input_overvolt_fault =
    conv_gate(inject_q[fic_pkg::BIT_IN_OV_F], conv_enable_in);
  assign fault_d.inject_output_undervolt_fault =
    conv_gate(inject_q[fic_pkg::BIT_OUT_UV_F], conv_enable_in);
  // warnings are gated like the non-exempt faults
  assign warn_d.inject_overcurrent_warning =
    conv_gate(inject_q[fic_pkg::BIT_OVERCURRENT_W], conv_enable_in);
  assign warn_d.inject_input_undervolt_warning =
    conv_gate(inject_q[fic_pkg::BIT_IN_UV_W], conv_enable_in);
  assign warn_d.inject_output_undervolt_warning =
    conv_gate(inject_q[fic_pkg::BIT_OUT_UV_W], conv_enable_in);
  assign warn_d.inject_output_overvolt_warning =
    conv_gate(inject_q[fic_pkg::BIT_OUT_OV_W], conv_enable_in);

  // injection register, volatile, cleared by reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      inject_q <= fic_pkg::INJECT_RESET;
    end else begin
      inject_q <= inject_d;
    end
  end

  // forced fault outputs, registered so the fault path sees clean levels
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_q <= '0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // forced warning outputs, same timing as the faults
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      warn_q <= '0;
    end else begin
      warn_q <= warn_d;
    end
  end

  // read acknowledge, one cycle after an accepted read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= read_ok;
    end
  end

  // refusal pulse, one cycle after a refused read or write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nack_q <= 1'b0;
    end else begin
      nack_q <= nack_d;
    end
  end

  // read word, held until the next accepted read replaces it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_q <= 16'h0000;
    end else if (read_ok) begin
      rd_data_q <= rd_data_d;
    end
  end

  // one-shot boot request in the first cycle after reset release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // checksum walker; result held between passes
  fic_crc_engine u_crc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(crc_start),
    .nvm_data_in(nvm_data_in),
    .nvm_addr_out(nvm_addr_out),
    .busy_out(crc_busy_out),
    .crc_out(crc_value)
  );

  // every output leaves straight from its flop
  assign rd_data_out = rd_data_q;
  assign rd_ack_out = rd_ack_q;
  assign cmd_nack_out = nack_q;
  assign fault_force_out = fault_q;
  assign warn_force_out = warn_q;

endmodule : fic_top
`default_nettype wire

// ### tb/fic_top_properties.sv
// port assertions for fic_top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module fic_top_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic wr_word_in,
  input wire logic [15:0] wr_data_in,
  input wire logic rd_word_in,
  input wire logic store_done_in,
  input wire logic conv_enable_in,
  input wire logic fault_response_in,
  input wire logic [7:0] nvm_addr_out,
  input wire logic rd_ack_out,
  input wire logic cmd_nack_out,
  input wire logic crc_busy_out,
  input wire fic_pkg::fic_fault_t fault_force_out,
  input wire fic_pkg::fic_warn_t warn_force_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // shadow of the last injection word; persist bits never self-clear
  logic [15:0] w_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) w_q <= 16'h0000;
    else if (wr_word_in && cmd_code_in == 8'hF1) w_q <= wr_data_in;
  end
  a_read_ack: assert property (rd_word_in && cmd_code_in inside {8'hF0,
    8'hF1} |=> rd_ack_out && !cmd_nack_out) else $error("read not acked");
  a_crc_write_nack: assert property (wr_word_in && cmd_code_in == 8'hF0
    |=> cmd_nack_out && !rd_ack_out) else $error("crc write taken");
  a_reset_clear: assert property (disable iff (1'b0) rst_in |=>
    fault_force_out == 6'h00 && warn_force_out == 4'h0)
    else $error("forces set after reset");
  a_lockout_free: assert property (wr_word_in && cmd_code_in == 8'hF1 &&
    wr_data_in[11] ##1 !wr_word_in |=> fault_force_out.inject_input_lockout)
    else $error("lockout not forced");
  a_gate_off: assert property (!conv_enable_in |=>
    (fault_force_out & 6'h36) == 6'h00 && warn_force_out == 4'h0)
    else $error("gated force while off");
  a_fault_oneshot: assert property (fault_response_in && !wr_word_in &&
    !w_q[15] ##1 !wr_word_in |=> fault_force_out == 6'h00)
    else $error("fault kept after response");
  a_warn_oneshot: assert property (fault_response_in && !wr_word_in &&
    !w_q[7] ##1 !wr_word_in |=> warn_force_out == 4'h0)
    else $error("warning kept after response");
  a_persist_hold: assert property (fault_response_in && !wr_word_in &&
    w_q[15] && w_q[11] ##1 !wr_word_in |=>
    fault_force_out.inject_input_lockout) else $error("persist lost");
  a_walk_start: assert property (store_done_in |=>
    crc_busy_out && nvm_addr_out == 8'h00) else $error("walk not started");
endmodule : fic_top_properties
bind fic_top fic_top_properties chk_u (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .cmd_code_in(cmd_code_in),
  .wr_word_in(wr_word_in),
  .wr_data_in(wr_data_in),
  .rd_word_in(rd_word_in),
  .store_done_in(store_done_in),
  .conv_enable_in(conv_enable_in),
  .fault_response_in(fault_response_in),
  .nvm_addr_out(nvm_addr_out),
  .rd_ack_out(rd_ack_out),
  .cmd_nack_out(cmd_nack_out),
  .crc_busy_out(crc_busy_out),
  .fault_force_out(fault_force_out),
  .warn_force_out(warn_force_out)
);
`default_nettype wire

// ### tb/fic_store_model.sv
// settings store model, one-cycle read latency
// assumes bank_in changes only around a store or restore
`timescale 1ns/10ps
`default_nettype none
module fic_store_model (
  input wire logic clk_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] bank_in,
  output logic [7:0] data_out
);
  // contents hang on bank_in so a reload really changes the checksum
  always_ff @(posedge clk_in) begin
    data_out <= (addr_in * 8'h1D) ^ bank_in;
  end
endmodule : fic_store_model
`default_nettype wire

// ### tb/fic_top_bench.sv
// self-checking bench for fic_top
// assumes fic_store_model as settings store and a 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module fic_top_bench;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_word_in = 1'b0, rd_word_in = 1'b0;
  logic store_done_in = 1'b0, restore_done_in = 1'b0, conv_enable_in = 1'b0;
  logic fault_response_in = 1'b0, rd_ack_out, cmd_nack_out, crc_busy_out;
  logic [7:0] cmd_code_in = 8'h00, bank = 8'h00, nvm_data_in, nvm_addr_out;
  logic [15:0] wr_data_in = 16'h0000, rd_data_out;
  fic_pkg::fic_fault_t fault_force_out;
  fic_pkg::fic_warn_t warn_force_out;
  int failures = 0, comparisons = 0;
  logic [31:0] seed = 32'h0000_2D94;
  always #2.5 clk_in = ~clk_in;
  fic_top dut_u (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cmd_code_in(cmd_code_in),
    .wr_word_in(wr_word_in),
    .wr_data_in(wr_data_in),
    .rd_word_in(rd_word_in),
    .store_done_in(store_done_in),
    .restore_done_in(restore_done_in),
    .conv_enable_in(conv_enable_in),
    .fault_response_in(fault_response_in),
    .nvm_data_in(nvm_data_in),
    .nvm_addr_out(nvm_addr_out),
    .rd_data_out(rd_data_out),
    .rd_ack_out(rd_ack_out),
    .cmd_nack_out(cmd_nack_out),
    .crc_busy_out(crc_busy_out),
    .fault_force_out(fault_force_out),
    .warn_force_out(warn_force_out)
  );
  fic_store_model mem_u (.clk_in(clk_in), .addr_in(nvm_addr_out),
    .bank_in(bank), .data_out(nvm_data_in));
  // xorshift keeps every run identical
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // msb-first crc over the whole store for one bank value
  function automatic logic [15:0] exp_crc(input logic [7:0] b);
    logic [15:0] c;
    c = 16'h0000;
    for (int a = 0; a < 256; a++) begin
      c ^= {8'(a * 29) ^ b, 8'h00};
      for (int i = 0; i < 8; i++) begin
        c = {c[14:0], 1'b0} ^ (c[15] ? 16'h8005 : 16'h0000);
      end
    end
    return c;
  endfunction : exp_crc
  // forced outputs for word d, conversion c, after a response when r
  function automatic logic [9:0] exp_frc(input logic [15:0] d,
                                         input logic c, input logic r);
    logic [15:0] q;
    q = d & 16'hDF9B;
    if (r && !q[15]) q &= 16'hA0FF;
    if (r && !q[7]) q &= 16'hFFE4;
    return {q[14] & c, q[12] & c, q[11], q[10] & c, q[9] & c, q[8],
            q[4] & c, q[3] & c, q[1] & c, q[0] & c};
  endfunction : exp_frc
  // one word read or write; the answer is settled on return
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_in);
    cmd_code_in <= c;
    wr_data_in <= d;
    wr_word_in <= w;
    rd_word_in <= !w;
    @(posedge clk_in);
    wr_word_in <= 1'b0;
    rd_word_in <= 1'b0;
    #1;
  endtask : xfer
  // bounded wait for the checksum walk to finish
  task automatic wait_idle();
    repeat (3) @(posedge clk_in);
    #1;
    for (int i = 0; i < 400 && crc_busy_out !== 1'b0; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (crc_busy_out !== 1'b0) begin
      failures++;
      end_of_test();
    end
  endtask : wait_idle
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    logic [15:0] d, cr;
    logic [7:0] b;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    xfer(1'b0, 8'hF1, 16'h0000);
    `CHK("inject_rst", 16'h0000, rd_data_out)
    `CHK("force_rst", 10'h000, {fault_force_out, warn_force_out})
    wait_idle();
    xfer(1'b0, 8'hF0, 16'h0000);
    `CHK("crc_boot", exp_crc(8'h00), rd_data_out)
    `CHK("crc_ack", 1'b1, rd_ack_out)
    xfer(1'b1, 8'hF0, 16'h1234);
    `CHK("crc_wr_nack", 1'b1, cmd_nack_out)
    xfer(1'b0, 8'h22, 16'h0000);
    `CHK("bad_rd_nack", 1'b1, cmd_nack_out)
    `CHK("bad_rd_ack", 1'b0, rd_ack_out)
    $display("test access done");
    // a restore, then a store, each with new store contents
    for (int k = 0; k < 2; k++) begin
      cr = exp_crc(bank);
      b = 8'(rnd());
      @(posedge clk_in);
      bank <= b;
      store_done_in <= k[0];
      restore_done_in <= !k[0];
      @(posedge clk_in);
      store_done_in <= 1'b0;
      restore_done_in <= 1'b0;
      xfer(1'b0, 8'hF0, 16'h0000);
      `CHK("crc_old", cr, rd_data_out)
      wait_idle();
      xfer(1'b0, 8'hF0, 16'h0000);
      `CHK("crc_new", exp_crc(b), rd_data_out)
    end
    $display("test checksum done");
    // first two words set every select, conversion off then on
    for (int n = 0; n < 40; n++) begin
      d = (n < 2) ? 16'hFFFF : 16'(rnd());
      @(posedge clk_in);
      conv_enable_in <= (n < 2) ? n[0] : seed[3];
      xfer(1'b1, 8'hF1, d);
      xfer(1'b0, 8'hF1, 16'h0000);
      `CHK("inject_rd", d & 16'hDF9B, rd_data_out)
      `CHK("force", exp_frc(d, conv_enable_in, 1'b0),
        {fault_force_out, warn_force_out})
      @(posedge clk_in);
      fault_response_in <= 1'b1;
      @(posedge clk_in);
      fault_response_in <= 1'b0;
      @(posedge clk_in);
      #1;
      `CHK("after_resp", exp_frc(d, conv_enable_in, 1'b1),
        {fault_force_out, warn_force_out})
    end
    $display("test inject done");
    end_of_test();
  end
endmodule : fic_top_bench
`default_nettype wire
